// [inval_pkg.sv]
// Function
// - register path takes requests via a 64-bit command and a 64-bit address register
// - global, domain and page scopes; unsupported scope runs coarser
// - global translation invalidation also drops all cached non-leaf entries
// - domain invalidation drops non-leaf entries for that domain or globally
// - page invalidation with keep hint set preferably keeps non-leaf entries
// - page invalidation with keep hint clear drops affected non-leaf entries
// - reported scope is the scope applied to the translation cache
// - head indexes next descriptor; advanced after fetching a valid one
// - ring is empty whenever head equals tail
// - ordered enable sequence; device then sets ring enabled status
// - fetch in order only when enabled, non-empty and both faults clear
// - head advances only after the fetched descriptor is found valid
// - on disable the head returns to zero and status clears
// - descriptors are 128 bits; type sits in bits 3:0
// - context descriptor carries scope, domain, requester and mask
// - flush write buffer before context invalidation when capability set
// - device-scope context flush hits only that device in that domain
package inval_pkg;
  // ----------------------------------------------------------------
  // register offsets (byte addresses)
  // ----------------------------------------------------------------
  localparam logic [7:0] OFS_CMD_LO    = 8'h00;
  localparam logic [7:0] OFS_CMD_HI    = 8'h04;
  localparam logic [7:0] OFS_ADDR_LO   = 8'h08;
  localparam logic [7:0] OFS_ADDR_HI   = 8'h0C;
  localparam logic [7:0] OFS_GCMD      = 8'h10;
  localparam logic [7:0] OFS_GSTS      = 8'h14;
  localparam logic [7:0] OFS_RING_LO   = 8'h18;
  localparam logic [7:0] OFS_RING_HI   = 8'h1C;
  localparam logic [7:0] OFS_HEAD      = 8'h20;
  localparam logic [7:0] OFS_TAIL      = 8'h24;
  localparam logic [7:0] OFS_FAULT     = 8'h28;
  localparam logic [7:0] OFS_CAP       = 8'h2C;
  // ----------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------
  localparam int CMD_START_BIT = 31;  // high word of command register
  localparam int CMD_REQ_LSB   = 28;
  localparam int CMD_ACT_LSB   = 25;
  localparam int ADDR_KEEP_BIT = 6;
  localparam int PAGE_LSB      = 12;
  localparam int RING_EN_BIT   = 0;
  localparam int RING_SIZE_W   = 3;
  localparam int SLOT_LOG_MIN  = 8;   // 4 KiB page holds 256 descriptors
  localparam int FAULT_Q_BIT   = 0;
  localparam int FAULT_T_BIT   = 1;
  localparam int CAP_FLUSH_BIT = 0;
  localparam int CAP_NL_BIT    = 1;
  localparam int DESC_BYTES_LOG = 4;
  // descriptor layout
  localparam int D_TYPE_LSB = 0;
  localparam int D_SCOPE_LSB = 4;
  localparam int D_DOM_LSB  = 16;
  localparam int D_REQ_LSB  = 32;
  localparam int D_MASK_LSB = 48;
  localparam int D_AM_LSB   = 64;
  localparam int D_KEEP_BIT = 70;
  localparam int D_PAGE_LSB = 76;
  localparam logic [1:0] RESP_OK  = 2'h0;
  localparam logic [1:0] RESP_ERR = 2'h2;
  // ----------------------------------------------------------------
  // encodings and carriers
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {SCOPE_NONE = 2'h0, SCOPE_GLOBAL = 2'h1,
    SCOPE_DOMAIN = 2'h2, SCOPE_PAGE = 2'h3} scope_type;
  typedef enum logic [3:0] {DESC_CTX = 4'h1, DESC_TLB = 4'h2,
    DESC_WAIT = 4'h5} desc_kind_type;
  typedef enum logic [1:0] {TGT_CTX = 2'h0, TGT_TLB = 2'h1,
    TGT_NONLEAF = 2'h2} target_type;
  typedef struct packed {
    target_type  target;
    scope_type   scope;
    logic [15:0] domain;
    logic [15:0] requester;
    logic [1:0]  req_mask;
    logic [51:0] page;
    logic [5:0]  addr_mask;
  } cache_op_type;
endpackage : inval_pkg

// [inval_front.sv]
`timescale 1ns/1ps
module inval_front
  import inval_pkg::*;
#(
  parameter int   HEAD_W        = 15,
  parameter bit   PAGE_OK       = 1'b1,
  parameter bit   NONLEAF_CACHE = 1'b1,
  parameter bit   FLUSH_CAP     = 1'b1
) (
  input  wire logic         clk,
  input  wire logic         rst,
  input  wire logic [7:0]   awaddr,
  input  wire logic         awvalid,
  output logic              awready,
  input  wire logic [31:0]  wdata,
  input  wire logic [3:0]   wstrb,
  input  wire logic         wvalid,
  output logic              wready,
  output logic [1:0]        bresp,
  output logic              bvalid,
  input  wire logic         bready,
  input  wire logic [7:0]   araddr,
  input  wire logic         arvalid,
  output logic              arready,
  output logic [31:0]       rdata,
  output logic [1:0]        rresp,
  output logic              rvalid,
  input  wire logic         rready,
  output logic              fetch_valid,
  input  wire logic         fetch_ready,
  output logic [63:0]       fetch_addr,
  input  wire logic         fetch_rvalid,
  input  wire logic [127:0] fetch_rdata,
  output logic              flush_req,
  input  wire logic         flush_ack,
  output logic              op_valid,
  input  wire logic         op_ready,
  output cache_op_type      op,
  input  wire logic         timeout_event
);
  initial begin
    if (HEAD_W < SLOT_LOG_MIN + (1 << RING_SIZE_W) - 1 || HEAD_W > 31)
      $error("HEAD_W cannot index the largest ring");
  end

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {ST_IDLE = 3'h0, ST_FETCH = 3'h1,
    ST_WAITD = 3'h3, ST_FLUSH = 3'h2, ST_MAIN = 3'h6, ST_NONLEAF = 3'h7,
    ST_FINISH = 3'h5} state_type;

  state_type         state_reg;
  state_type         state_next;
  logic [31:0]       cmd_hi_reg;
  logic [31:0]       addr_lo_reg;
  logic [31:0]       addr_hi_reg;
  logic              ring_en_reg;
  logic              ring_on_reg;
  logic [31:0]       ring_lo_reg;
  logic [31:0]       ring_hi_reg;
  logic [HEAD_W-1:0] head_reg;
  logic [HEAD_W-1:0] tail_reg;
  logic              qfault_reg;
  logic              tfault_reg;
  logic              from_ring_reg;
  logic              nl_pend_reg;
  scope_type         act_scope_reg;
  cache_op_type      main_reg;
  cache_op_type      nl_reg;
  cache_op_type      op_reg;
  logic [63:0]       fetch_addr_reg;
  logic [7:0]        aw_addr_reg;
  logic [31:0]       w_data_reg;
  logic [3:0]        w_strb_reg;
  logic              aw_full_reg;
  logic              w_full_reg;
  logic              bvalid_reg;
  logic [1:0]        bresp_reg;
  logic              rvalid_reg;
  logic [31:0]       rdata_reg;
  logic [1:0]        rresp_reg;

  // ----------------------------------------------------------------
  // bus slave
  // ----------------------------------------------------------------
  logic        wr_go;
  logic        wr_hit;
  logic [31:0] rd_val;
  logic        rd_hit;

  function automatic logic [31:0] merge(input logic [31:0] old,
                                        input logic [31:0] val,
                                        input logic [3:0]  strb);
    logic [31:0] res;
    res = old;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        res[i*8 +: 8] = val[i*8 +: 8];
      end
    end
    return res;
  endfunction : merge

  assign awready = !aw_full_reg && !bvalid_reg;
  assign wready  = !w_full_reg && !bvalid_reg;
  assign wr_go   = aw_full_reg && w_full_reg && !bvalid_reg;
  assign bvalid  = bvalid_reg;
  assign bresp   = bresp_reg;
  assign arready = !rvalid_reg;
  assign rvalid  = rvalid_reg;
  assign rdata   = rdata_reg;
  assign rresp   = rresp_reg;

  always_ff @(posedge clk) begin
    if (rst) begin
      aw_full_reg <= 1'b0;
      w_full_reg  <= 1'b0;
      aw_addr_reg <= 8'h00;
      w_data_reg  <= 32'h0000_0000;
      w_strb_reg  <= 4'h0;
    end else begin
      if (awvalid && awready) begin
        aw_full_reg <= 1'b1;
        aw_addr_reg <= awaddr;
      end else if (wr_go) begin
        aw_full_reg <= 1'b0;
      end
      if (wvalid && wready) begin
        w_full_reg <= 1'b1;
        w_data_reg <= wdata;
        w_strb_reg <= wstrb;
      end else if (wr_go) begin
        w_full_reg <= 1'b0;
      end
    end
  end

  assign wr_hit = aw_addr_reg <= OFS_CAP && aw_addr_reg[1:0] == 2'h0;

  always_ff @(posedge clk) begin
    if (rst) begin
      bvalid_reg <= 1'b0;
      bresp_reg  <= RESP_OK;
    end else if (wr_go) begin
      bvalid_reg <= 1'b1;
      bresp_reg  <= wr_hit ? RESP_OK : RESP_ERR;
    end else if (bready) begin
      bvalid_reg <= 1'b0;
    end
  end

  always_comb begin
    rd_hit = 1'b1;
    rd_val = 32'h0000_0000;
    if (araddr == OFS_CMD_LO) rd_val = 32'h0000_0000;
    else if (araddr == OFS_CMD_HI) rd_val = cmd_hi_reg;
    else if (araddr == OFS_ADDR_LO) rd_val = addr_lo_reg;
    else if (araddr == OFS_ADDR_HI) rd_val = addr_hi_reg;
    else if (araddr == OFS_GCMD) rd_val[RING_EN_BIT] = ring_en_reg;
    else if (araddr == OFS_GSTS) rd_val[RING_EN_BIT] = ring_on_reg;
    else if (araddr == OFS_RING_LO) rd_val = ring_lo_reg;
    else if (araddr == OFS_RING_HI) rd_val = ring_hi_reg;
    else if (araddr == OFS_HEAD) rd_val[HEAD_W-1:0] = head_reg;
    else if (araddr == OFS_TAIL) rd_val[HEAD_W-1:0] = tail_reg;
    else if (araddr == OFS_FAULT) begin
      rd_val[FAULT_Q_BIT] = qfault_reg;
      rd_val[FAULT_T_BIT] = tfault_reg;
    end else if (araddr == OFS_CAP) begin
      rd_val[CAP_FLUSH_BIT] = FLUSH_CAP;
      rd_val[CAP_NL_BIT]    = NONLEAF_CACHE;
    end else rd_hit = 1'b0;
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      rvalid_reg <= 1'b0;
      rdata_reg  <= 32'h0000_0000;
      rresp_reg  <= RESP_OK;
    end else if (arvalid && arready) begin
      rvalid_reg <= 1'b1;
      rdata_reg  <= rd_val;
      rresp_reg  <= rd_hit ? RESP_OK : RESP_ERR;
    end else if (rready) begin
      rvalid_reg <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // software registers
  // ----------------------------------------------------------------
  logic wr_cmd;
  logic wr_tail;
  logic finish_reg_path;
  assign wr_cmd  = wr_go && aw_addr_reg == OFS_CMD_HI;
  assign wr_tail = wr_go && aw_addr_reg == OFS_TAIL;
  assign finish_reg_path = state_reg == ST_FINISH && !from_ring_reg;

  always_ff @(posedge clk) begin
    if (rst) begin
      cmd_hi_reg <= 32'h0000_0000;
    end else if (finish_reg_path) begin
      cmd_hi_reg[CMD_START_BIT] <= 1'b0;
      cmd_hi_reg[CMD_ACT_LSB +: 2] <= act_scope_reg;
    end else if (wr_cmd && !cmd_hi_reg[CMD_START_BIT]) begin
      cmd_hi_reg <= merge(cmd_hi_reg, w_data_reg, w_strb_reg);
      cmd_hi_reg[CMD_ACT_LSB +: 2] <= cmd_hi_reg[CMD_ACT_LSB +: 2];
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      addr_lo_reg <= 32'h0000_0000;
      addr_hi_reg <= 32'h0000_0000;
      ring_lo_reg <= 32'h0000_0000;
      ring_hi_reg <= 32'h0000_0000;
      ring_en_reg <= 1'b0;
    end else if (wr_go) begin
      if (aw_addr_reg == OFS_ADDR_LO)
        addr_lo_reg <= merge(addr_lo_reg, w_data_reg, w_strb_reg);
      else if (aw_addr_reg == OFS_ADDR_HI)
        addr_hi_reg <= merge(addr_hi_reg, w_data_reg, w_strb_reg);
      else if (aw_addr_reg == OFS_RING_LO)
        ring_lo_reg <= merge(ring_lo_reg, w_data_reg, w_strb_reg);
      else if (aw_addr_reg == OFS_RING_HI)
        ring_hi_reg <= merge(ring_hi_reg, w_data_reg, w_strb_reg);
      else if (aw_addr_reg == OFS_GCMD && w_strb_reg[0])
        ring_en_reg <= w_data_reg[RING_EN_BIT];
    end
  end

  // tail is software owned; head only moves by hardware
  always_ff @(posedge clk) begin
    if (rst) begin
      tail_reg <= '0;
    end else if (wr_tail) begin
      tail_reg <= w_data_reg[HEAD_W-1:0];
    end
  end

  // hardware set wins over a software write-one-to-clear
  logic [1:0] fault_clr;
  logic       fault_set_q;
  assign fault_clr = (wr_go && aw_addr_reg == OFS_FAULT && w_strb_reg[0])
                   ? w_data_reg[1:0] : 2'h0;
  always_ff @(posedge clk) begin
    if (rst) begin
      qfault_reg <= 1'b0;
      tfault_reg <= 1'b0;
    end else begin
      qfault_reg <= fault_set_q || (qfault_reg && !fault_clr[FAULT_Q_BIT]);
      tfault_reg <= timeout_event ||
                    (tfault_reg && !fault_clr[FAULT_T_BIT]);
    end
  end

  // ----------------------------------------------------------------
  // ring pointers
  // ----------------------------------------------------------------
  logic [HEAD_W-1:0] head_inc;
  logic [HEAD_W:0]   slots;
  logic              ring_empty;
  logic              may_fetch;
  logic              head_adv;
  desc_kind_type     dkind;
  assign head_inc   = head_reg + 1'b1;
  assign slots = (HEAD_W+1)'(1) << (SLOT_LOG_MIN + ring_lo_reg[2:0]);
  assign ring_empty = head_reg == tail_reg;
  assign may_fetch  = ring_on_reg && !ring_empty && !qfault_reg
                   && !tfault_reg;
  assign dkind      = desc_kind_type'(fetch_rdata[D_TYPE_LSB +: 4]);
  assign head_adv   = state_reg == ST_WAITD && fetch_rvalid &&
                      (dkind == DESC_CTX || dkind == DESC_TLB ||
                       dkind == DESC_WAIT);
  assign fault_set_q = state_reg == ST_WAITD && fetch_rvalid && !head_adv;

  always_ff @(posedge clk) begin
    if (rst) begin
      head_reg    <= '0;
      ring_on_reg <= 1'b0;
    end else begin
      ring_on_reg <= ring_en_reg;
      if (!ring_en_reg) begin
        head_reg <= '0;
      end else if (head_adv) begin
        head_reg <= ({1'b0, head_inc} == slots) ? '0 : head_inc;
      end
    end
  end

  // ----------------------------------------------------------------
  // scope resolution for translation requests
  // ----------------------------------------------------------------
  scope_type   req_scope;
  scope_type   tlb_scope;
  scope_type   nl_scope;
  logic        keep_hint;
  logic [15:0] src_dom;
  logic [51:0] src_page;
  logic [5:0]  src_am;
  always_comb begin
    if (state_reg == ST_WAITD) begin
      req_scope = scope_type'(fetch_rdata[D_SCOPE_LSB +: 2]);
      keep_hint = fetch_rdata[D_KEEP_BIT];
      src_dom   = fetch_rdata[D_DOM_LSB +: 16];
      src_page  = fetch_rdata[D_PAGE_LSB +: 52];
      src_am    = fetch_rdata[D_AM_LSB +: 6];
    end else begin
      req_scope = scope_type'(cmd_hi_reg[CMD_REQ_LSB +: 2]);
      keep_hint = addr_lo_reg[ADDR_KEEP_BIT];
      src_dom   = cmd_hi_reg[15:0];
      src_page  = {addr_hi_reg, addr_lo_reg[31:PAGE_LSB]};
      src_am    = addr_lo_reg[5:0];
    end
    // a reserved or unsupported scope falls back to a coarser one
    tlb_scope = req_scope;
    if (req_scope == SCOPE_NONE) tlb_scope = SCOPE_GLOBAL;
    else if (req_scope == SCOPE_PAGE && !PAGE_OK) tlb_scope = SCOPE_DOMAIN;
    nl_scope = tlb_scope;
    if (tlb_scope == SCOPE_PAGE && keep_hint) nl_scope = SCOPE_NONE;
    // without the hint, page scope drops only the addressed entries
    if (!NONLEAF_CACHE) nl_scope = SCOPE_NONE;
  end

  // ----------------------------------------------------------------
  // sequencer
  // ----------------------------------------------------------------
  logic start_reg_path;
  logic to_flush;
  assign start_reg_path = cmd_hi_reg[CMD_START_BIT] && !ring_on_reg;
  assign to_flush = FLUSH_CAP && dkind != DESC_WAIT;

  always_comb begin
    state_next = state_reg;
    case (state_reg)
      ST_IDLE: begin
        if (start_reg_path) state_next = ST_MAIN;
        else if (may_fetch) state_next = ST_FETCH;
      end
      ST_FETCH: begin
        if (fetch_ready) state_next = ST_WAITD;
      end
      ST_WAITD: begin
        if (fetch_rvalid) begin
          if (!head_adv || dkind == DESC_WAIT) state_next = ST_IDLE;
          else if (to_flush) state_next = ST_FLUSH;
          else state_next = ST_MAIN;
        end
      end
      ST_FLUSH: begin
        if (flush_ack) state_next = ST_MAIN;
      end
      ST_MAIN: begin
        if (op_ready) state_next = nl_pend_reg ? ST_NONLEAF : ST_FINISH;
      end
      ST_NONLEAF: begin
        if (op_ready) state_next = ST_FINISH;
      end
      default: state_next = ST_IDLE;
    endcase
  end

  always_ff @(posedge clk) begin
    if (rst) state_reg <= ST_IDLE;
    else state_reg <= state_next;
  end

  // operation capture for both paths
  always_ff @(posedge clk) begin
    if (rst) begin
      main_reg      <= '0;
      nl_reg        <= '0;
      nl_pend_reg   <= 1'b0;
      act_scope_reg <= SCOPE_NONE;
      from_ring_reg <= 1'b0;
    end else if ((state_reg == ST_IDLE && start_reg_path) ||
                 (state_reg == ST_WAITD && head_adv)) begin
      from_ring_reg <= state_reg == ST_WAITD;
      act_scope_reg <= tlb_scope;
      nl_pend_reg   <= nl_scope != SCOPE_NONE;
      main_reg <= '{TGT_TLB, tlb_scope, src_dom, 16'h0000, 2'h0,
                    src_page, src_am};
      nl_reg   <= '{TGT_NONLEAF, nl_scope, src_dom, 16'h0000, 2'h0,
                    src_page, src_am};
      if (state_reg == ST_WAITD && dkind == DESC_CTX) begin
        nl_pend_reg <= 1'b0;
        main_reg <= '{TGT_CTX,
          (req_scope == SCOPE_NONE) ? SCOPE_GLOBAL : req_scope,
          fetch_rdata[D_DOM_LSB +: 16], fetch_rdata[D_REQ_LSB +: 16],
          fetch_rdata[D_MASK_LSB +: 2], 52'h0, 6'h00};
      end
    end
  end

  // ----------------------------------------------------------------
  // outputs toward memory and caches
  // ----------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (rst) begin
      fetch_addr_reg <= 64'h0;
      op_reg         <= '0;
    end else begin
      if (state_next == ST_FETCH && state_reg == ST_IDLE)
        fetch_addr_reg <= {ring_hi_reg, ring_lo_reg[31:PAGE_LSB],
          12'h000} + (64'(head_reg) << DESC_BYTES_LOG);
      if (state_next == ST_MAIN) op_reg <= main_reg;
      if (state_next == ST_NONLEAF) op_reg <= nl_reg;
    end
  end

  // the main op is offered straight from main_reg, which loads on or before the edge on which the offer can start
  assign fetch_valid = state_reg == ST_FETCH;
  assign fetch_addr  = fetch_addr_reg;
  assign flush_req   = state_reg == ST_FLUSH;
  assign op_valid    = (state_reg == ST_MAIN || state_reg == ST_NONLEAF);
  assign op          = (state_reg == ST_MAIN) ? main_reg : op_reg;
endmodule : inval_front

// [inval_front_checker.sv]
`timescale 1ns/1ps
// ----
// port checks
// ----
module inval_front_checker
  import inval_pkg::*;
(
  input wire logic          clk,
  input wire logic          rst,
  input wire logic          awready,
  input wire logic [1:0]    bresp,
  input wire logic          bvalid,
  input wire logic          bready,
  input wire logic [31:0]   rdata,
  input wire logic          rvalid,
  input wire logic          rready,
  input wire logic          fetch_valid,
  input wire logic          fetch_ready,
  input wire logic [63:0]   fetch_addr,
  input wire logic          fetch_rvalid,
  input wire logic [127:0]  fetch_rdata,
  input wire logic          flush_ack,
  input wire logic          op_valid,
  input wire logic          op_ready,
  input wire cache_op_type  op
);
  logic flushed_reg;
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  // each context op needs a flush after its own descriptor returned
  always_ff @(posedge clk) begin
    if (rst || fetch_rvalid) flushed_reg <= 1'b0;
    else if (flush_ack) flushed_reg <= 1'b1;
  end
  bresp_hold_a: assert property (bvalid && !bready |=>
    bvalid && $stable(bresp)) else $error("write answer dropped");
  rdata_hold_a: assert property (rvalid && !rready |=>
    rvalid && $stable(rdata)) else $error("read answer dropped");
  aw_block_a: assert property (bvalid |-> !awready)
    else $error("address taken during answer");
  fetch_hold_a: assert property (fetch_valid && !fetch_ready |=>
    fetch_valid && $stable(fetch_addr)) else $error("fetch moved");
  fetch_align_a: assert property (fetch_valid |->
    fetch_addr[3:0] == 4'h0) else $error("fetch not on a slot");
  bad_stop_a: assert property (fetch_rvalid && !(fetch_rdata[3:0]
    inside {DESC_CTX, DESC_TLB, DESC_WAIT}) |=>
    (!fetch_valid && !op_valid) [*4]) else $error("bad descriptor used");
  ctx_flush_a: assert property (op_valid && op.target == TGT_CTX
    |-> flushed_reg) else $error("context op before flush");
  glob_nl_a: assert property (op_valid && op_ready
    && op.target == TGT_TLB && op.scope == SCOPE_GLOBAL |-> ##[1:20]
    (op_valid && op.target == TGT_NONLEAF && op.scope == SCOPE_GLOBAL))
    else $error("no global non-leaf op");
  dom_nl_a: assert property (op_valid && op_ready
    && op.target == TGT_TLB && op.scope == SCOPE_DOMAIN |-> ##[1:20]
    (op_valid && op.target == TGT_NONLEAF && op.scope != SCOPE_PAGE))
    else $error("no domain non-leaf op");
endmodule : inval_front_checker

bind inval_front inval_front_checker inval_front_checker_i (
  .clk(clk), .rst(rst), .awready(awready), .bresp(bresp),
  .bvalid(bvalid), .bready(bready), .rdata(rdata), .rvalid(rvalid),
  .rready(rready), .fetch_valid(fetch_valid), .fetch_ready(fetch_ready),
  .fetch_addr(fetch_addr), .fetch_rvalid(fetch_rvalid),
  .fetch_rdata(fetch_rdata), .flush_ack(flush_ack), .op_valid(op_valid),
  .op_ready(op_ready), .op(op));

// [ring_memory_model.sv]
`timescale 1ns/1ps
// ----
// descriptor memory and cache side
// ----
module ring_memory_model (
  input wire logic          clk,
  input wire logic          rst,
  input wire logic          fetch_valid,
  output logic              fetch_ready,
  input wire logic [63:0]   fetch_addr,
  output logic              fetch_rvalid,
  output logic [127:0]      fetch_rdata,
  input wire logic          flush_req,
  output logic              flush_ack,
  output logic              op_ready
);
  logic [127:0] mem [0:255];
  logic [3:0]   tick_reg;
  logic [2:0]   wait_reg;
  logic [7:0]   slot_reg;
  logic         busy_reg;
  assign fetch_ready = !busy_reg;
  // stall every other cycle so hold rules get exercised
  assign op_ready = tick_reg[0];
  always_ff @(posedge clk) begin
    tick_reg <= tick_reg + 4'h1;
    fetch_rvalid <= 1'b0;
    // idle data keeps changing so stale data never looks valid
    fetch_rdata <= ~fetch_rdata;
    flush_ack <= flush_req && !flush_ack && tick_reg[1];
    if (rst) begin
      tick_reg <= 4'h0;
      busy_reg <= 1'b0;
      flush_ack <= 1'b0;
      fetch_rdata <= '0;
    end else if (fetch_valid && !busy_reg) begin
      busy_reg <= 1'b1;
      slot_reg <= fetch_addr[11:4];
      wait_reg <= tick_reg[2:0];
    end else if (busy_reg && wait_reg == 3'h0) begin
      busy_reg <= 1'b0;
      fetch_rvalid <= 1'b1;
      fetch_rdata <= mem[slot_reg];
    end else if (busy_reg) begin
      wait_reg <= wait_reg - 3'h1;
    end
  end
endmodule : ring_memory_model

// [inval_front_tb.sv]
`timescale 1ns/1ps
module inval_front_tb
  import inval_pkg::*;
;
  logic          clk = 1'b0, rst = 1'b1, timeout_event = 1'b0;
  logic          awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
  logic          arvalid = 1'b0, rready = 1'b0;
  logic [7:0]    awaddr = 8'h00, araddr = 8'h00;
  logic [31:0]   wdata = 32'h0, rdata, rv;
  logic          awready, wready, bvalid, arready, rvalid, op_valid;
  logic          fetch_valid, fetch_ready, fetch_rvalid, flush_req;
  logic          flush_ack, op_ready;
  logic [1:0]    bresp, rresp, rr;
  logic [63:0]   fetch_addr;
  logic [127:0]  fetch_rdata;
  cache_op_type  op, exp_op;
  cache_op_type  ops [$];
  int            bad_count = 0, tests_run = 0;
  logic [1:0]    req [5] = '{2'h0, 2'h1, 2'h2, 2'h3, 2'h3};
  logic [1:0]    perf [5] = '{2'h1, 2'h1, 2'h2, 2'h3, 2'h3};
  logic          keep [5] = '{1'b0, 1'b0, 1'b0, 1'b0, 1'b1};
  always #2 clk = ~clk;
  inval_front inval_front_i (.clk(clk), .rst(rst), .awaddr(awaddr),
    .awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(4'hF),
    .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid),
    .bready(bready), .araddr(araddr), .arvalid(arvalid),
    .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid),
    .rready(rready), .fetch_valid(fetch_valid), .fetch_ready(fetch_ready),
    .fetch_addr(fetch_addr), .fetch_rvalid(fetch_rvalid),
    .fetch_rdata(fetch_rdata), .flush_req(flush_req),
    .flush_ack(flush_ack), .op_valid(op_valid), .op_ready(op_ready),
    .op(op), .timeout_event(timeout_event));
  ring_memory_model ring_memory_model_i (.clk(clk), .rst(rst),
    .fetch_valid(fetch_valid), .fetch_ready(fetch_ready),
    .fetch_addr(fetch_addr), .fetch_rvalid(fetch_rvalid),
    .fetch_rdata(fetch_rdata), .flush_req(flush_req),
    .flush_ack(flush_ack), .op_ready(op_ready));
  always @(posedge clk) if (op_valid && op_ready) ops.push_back(op);
  // ----
  // tasks
  // ----
  task automatic finish_test;
    $display("comparisons %0d mismatches %0d", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask : finish_test
  task automatic chk(input logic [127:0] s, input logic [127:0] e);
    tests_run++;
    if (s !== e) begin
      bad_count++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask : chk
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk);
    awaddr  <= a;
    wdata   <= d;
    awvalid <= 1'b1;
    wvalid  <= 1'b1;
    bready  <= 1'b1;
    do begin
      @(posedge clk);
      n++;
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
      if (bvalid) bready <= 1'b0;
    end while (!bvalid && n < 50);
    chk(128'({bvalid, bresp}), 128'({1'b1, RESP_OK}));
    if (n >= 50) finish_test();
  endtask : wr
  task automatic rd(input logic [7:0] a);
    int n;
    n = 0;
    @(posedge clk);
    araddr  <= a;
    arvalid <= 1'b1;
    rready  <= 1'b1;
    do begin
      @(posedge clk);
      n++;
      if (arready) arvalid <= 1'b0;
      rv = rdata;
      rr = rresp;
    end while (!rvalid && n < 50);
    rready <= 1'b0;
    if (n >= 50) chk(128'h0, 128'h1);
    if (n >= 50) finish_test();
  endtask : rd
  task automatic wait_rd(input logic [7:0] a, input logic [31:0] m,
                         input logic [31:0] e);
    int n;
    n = 0;
    do begin
      rd(a);
      n++;
    end while ((rv & m) !== e && n < 2000);
    chk(128'(rv & m), 128'(e));
    if (n >= 2000) finish_test();
  endtask : wait_rd
  // ----
  // sequence
  // ----
  initial begin
    for (int k = 0; k < 256; k++) ring_memory_model_i.mem[k] = 128'h5;
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    rd(8'h30);
    chk(128'(rr), 128'(RESP_ERR));
    rd(OFS_CAP);
    chk(128'(rv), 128'h3);
    $display("test reset done");
    for (int i = 0; i < 5; i++) begin
      ops.delete();
      wr(OFS_ADDR_LO, {20'h12345, 5'h0, keep[i], 6'h0});
      wr(OFS_CMD_HI, {2'b10, req[i], 12'h0, 16'h0007});
      wait_rd(OFS_CMD_HI, 32'h8000_0000, 32'h0);
      chk(128'(rv[26:25]), 128'(perf[i]));
      exp_op = '{TGT_TLB, scope_type'(perf[i]), 16'h7, 16'h0, 2'h0,
                 52'h12345, 6'h0};
      chk(128'(ops[0]), 128'(exp_op));
      chk(128'(ops.size()), 128'(2 - keep[i]));
    end
    $display("test register path done");
    wr(OFS_TAIL, 32'h0);
    wr(OFS_RING_LO, 32'h0000_1000);
    wr(OFS_RING_HI, 32'h0);
    wr(OFS_GCMD, 32'h1);
    wait_rd(OFS_GSTS, 32'h1, 32'h1);
    // reserved fields stay zero
    ring_memory_model_i.mem[0] = {78'h0, 2'h2, 16'h0105, 16'h0042,
                                  10'h0, 2'h3, 4'h1};
    ring_memory_model_i.mem[1] = {122'h0, 2'h1, 4'h2};
    exp_op = '{target: TGT_CTX, scope: SCOPE_PAGE, domain: 16'h0042,
               requester: 16'h0105, req_mask: 2'h2, default: '0};
    ops.delete();
    wr(OFS_TAIL, 32'h3);
    wait_rd(OFS_HEAD, 32'hFFFF, 32'h3);
    chk(128'(ops.size()), 128'h3);
    chk(128'(ops[0]), 128'(exp_op));
    wr(OFS_TAIL, 32'h0);
    wait_rd(OFS_HEAD, 32'hFFFF, 32'h0);
    $display("test ring done");
    ring_memory_model_i.mem[0] = 128'hF;
    wr(OFS_TAIL, 32'h1);
    wait_rd(OFS_FAULT, 32'h1, 32'h1);
    ring_memory_model_i.mem[0] = 128'h5;
    wr(OFS_TAIL, 32'h2);
    rd(OFS_HEAD);
    chk(128'(rv), 128'h0);
    wr(OFS_FAULT, 32'h1);
    wait_rd(OFS_HEAD, 32'hFFFF, 32'h2);
    @(posedge clk);
    timeout_event <= 1'b1;
    @(posedge clk);
    timeout_event <= 1'b0;
    wr(OFS_TAIL, 32'h3);
    rd(OFS_HEAD);
    chk(128'(rv), 128'h2);
    wr(OFS_FAULT, 32'h2);
    wait_rd(OFS_HEAD, 32'hFFFF, 32'h3);
    // ring is quiet and the last descriptor was a wait
    wr(OFS_GCMD, 32'h0);
    rd(OFS_GSTS);
    chk(128'(rv), 128'h0);
    rd(OFS_HEAD);
    chk(128'(rv), 128'h0);
    $display("test faults and disable done");
    finish_test();
  end
endmodule : inval_front_tb
